// ### hw/mbd_defs.vh
`ifndef MBD_DEFS_VH
`define MBD_DEFS_VH
// function codes and their exception forms
`define MBD_FN_WRMULTI 8'h10
`define MBD_FN_DIAG 8'h08
`define MBD_EXC_FLAG 8'h80
// exception codes
`define MBD_EXC_FUNC 8'h01
`define MBD_EXC_VALUE 8'h03
`define MBD_EXC_BUSY 8'h06
`define MBD_EXC_NAK 8'h07
// broadcast address
`define MBD_ADDR_BCAST 8'h00
// register count limits
`define MBD_CNT_MIN 16'h0001
`define MBD_CNT_MAX 16'h007b
`define MBD_BUF_DEPTH 123
// frame byte positions
`define MBD_POS_ADDR 8'h00
`define MBD_POS_FUNC 8'h01
`define MBD_POS_W1H 8'h02
`define MBD_POS_W1L 8'h03
`define MBD_POS_W2H 8'h04
`define MBD_POS_W2L 8'h05
`define MBD_POS_BCNT 8'h06
`define MBD_POS_DATA 8'h07
`define MBD_POS_MAX 8'hff
// payload length of a diagnostics request without crc
`define MBD_DIAG_LEN 8'h06
// diagnostic sub-functions
`define MBD_SUB_CLEAR 16'h000a
`define MBD_SUB_FIRST 16'h000b
`define MBD_SUB_LAST 16'h0012
// counter indices
`define MBD_C_BUS 0
`define MBD_C_COMM 1
`define MBD_C_EXC 2
`define MBD_C_SRV 3
`define MBD_C_NORSP 4
`define MBD_C_NAK 5
`define MBD_C_BUSY 6
`define MBD_C_OVR 7
`define MBD_NUM_CNT 8
// response lengths in bytes, crc excluded
`define MBD_LEN_EXC 3'd3
`define MBD_LEN_NORM 3'd6
`endif

// ### hw/mbd_server.v
`timescale 1ns/10ps
`default_nettype none
`include "mbd_defs.vh"

module mbd_server (
  input wire clk_sys,
  input wire resetn,
  input wire [7:0] dev_addr,
  input wire server_busy,
  input wire rx_valid,
  input wire [7:0] rx_byte,
  input wire rx_first,
  input wire rx_end,
  input wire rx_bad,
  input wire rx_ovr,
  input wire tx_ready,
  output reg tx_valid,
  output reg [7:0] tx_byte,
  output reg tx_last,
  output reg wr_en,
  output reg [15:0] wr_addr,
  output reg [15:0] wr_data
);

  // ----------------------------------------------------------------
  // state and storage
  // ----------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_COMMIT = 2'b01;
  localparam [1:0] ST_SEND = 2'b10;

  reg [1:0] state_reg;
  reg [7:0] idx_reg;
  reg [7:0] addr_reg;
  reg [7:0] func_reg;
  reg [15:0] w1_reg;
  reg [15:0] w2_reg;
  reg [7:0] bcnt_reg;
  reg [7:0] hold_reg;
  reg [15:0] buf_mem [0:`MBD_BUF_DEPTH-1];
  reg [6:0] wi_reg;
  reg [47:0] resp_reg;
  reg [2:0] rlen_reg;
  reg [2:0] rptr_reg;
  reg bcast_reg;
  reg lost_reg;

  wire [7:0] pos;
  wire [7:0] dword;
  wire [127:0] cnt_flat;
  reg [`MBD_NUM_CNT-1:0] ev;
  reg clr;

  // ----------------------------------------------------------------
  // request capture
  // ----------------------------------------------------------------
  assign pos = rx_first ? `MBD_POS_ADDR : idx_reg;
  assign dword = (pos - `MBD_POS_DATA) >> 1;

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      idx_reg <= 8'h00;
      addr_reg <= 8'h00;
      func_reg <= 8'h00;
      w1_reg <= 16'h0000;
      w2_reg <= 16'h0000;
      bcnt_reg <= 8'h00;
      hold_reg <= 8'h00;
    end else if (rx_valid && state_reg == ST_IDLE) begin
      if (pos != `MBD_POS_MAX)
        idx_reg <= pos + 8'h01;
      // stale fields of the last frame must not decode a short one
      if (rx_first) begin
        func_reg <= 8'h00;
        w1_reg <= 16'h0000;
        w2_reg <= 16'h0000;
        bcnt_reg <= 8'h00;
      end
      case (pos)
        `MBD_POS_ADDR: addr_reg <= rx_byte;
        `MBD_POS_FUNC: func_reg <= rx_byte;
        `MBD_POS_W1H: w1_reg[15:8] <= rx_byte;
        `MBD_POS_W1L: w1_reg[7:0] <= rx_byte;
        `MBD_POS_W2H: w2_reg[15:8] <= rx_byte;
        `MBD_POS_W2L: w2_reg[7:0] <= rx_byte;
        `MBD_POS_BCNT: bcnt_reg <= rx_byte;
        default: hold_reg <= rx_byte;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // write data buffer
  // ----------------------------------------------------------------
  // data words buffered in arrival order
  // words past the buffer are dropped; the length check rejects them
  always @(posedge clk_sys) begin
    if (rx_valid && state_reg == ST_IDLE && !rx_first &&
        pos > `MBD_POS_DATA && !pos[0] && dword < `MBD_BUF_DEPTH)
      buf_mem[dword[6:0]] <= {hold_reg, rx_byte};
  end

  // ----------------------------------------------------------------
  // frame loss
  // ----------------------------------------------------------------
  // bytes seen while committing or sending are dropped, so the rest
  // of that frame is never decoded; a first byte in idle clears it
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      lost_reg <= 1'b0;
    else if (rx_valid && state_reg != ST_IDLE)
      lost_reg <= 1'b1;
    else if (rx_valid && rx_first)
      lost_reg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  // broadcast frames are carried out but never answered
  wire for_us = addr_reg == dev_addr || addr_reg == `MBD_ADDR_BCAST;
  wire is_bc = addr_reg == `MBD_ADDR_BCAST;
  wire take = rx_end && state_reg == ST_IDLE && for_us && !lost_reg;
  // count range, byte count twice the count, whole frame seen
  wire wr_cnt_ok = w2_reg >= `MBD_CNT_MIN && w2_reg <= `MBD_CNT_MAX;
  wire wr_bcnt_ok = bcnt_reg == {w2_reg[6:0], 1'b0};
  wire wr_len_ok = idx_reg == `MBD_POS_DATA + bcnt_reg;
  wire wr_ok = wr_cnt_ok && wr_bcnt_ok && wr_len_ok;
  wire sub_ok = w1_reg >= `MBD_SUB_CLEAR && w1_reg <= `MBD_SUB_LAST;
  wire diag_len_ok = idx_reg == `MBD_DIAG_LEN;
  wire diag_data_ok = w2_reg == 16'h0000;
  wire diag_ok = diag_len_ok && diag_data_ok;
  wire [15:0] sub_off = w1_reg - `MBD_SUB_FIRST;
  wire [15:0] sel_cnt = cnt_flat[{sub_off[2:0], 4'h0} +: 16];

  // ----------------------------------------------------------------
  // exception select
  // ----------------------------------------------------------------
  reg [7:0] exc;
  reg go_commit;
  reg [15:0] reply_w2;
  always @* begin
    exc = 8'h00;
    go_commit = 1'b0;
    clr = 1'b0;
    reply_w2 = w2_reg;
    if (func_reg == `MBD_FN_WRMULTI) begin
      if (!wr_ok)
        exc = `MBD_EXC_VALUE;
      else if (server_busy)
        exc = `MBD_EXC_BUSY;
      else
        go_commit = 1'b1;
    end else if (func_reg == `MBD_FN_DIAG) begin
      if (!sub_ok)
        exc = `MBD_EXC_FUNC;
      else if (!diag_ok)
        exc = `MBD_EXC_VALUE;
      else if (w1_reg == `MBD_SUB_CLEAR)
        clr = take;
      else
        reply_w2 = sel_cnt;
    end else begin
      exc = `MBD_EXC_FUNC;
    end
  end

  // ----------------------------------------------------------------
  // diagnostic counters
  // ----------------------------------------------------------------
  always @* begin
    ev = {`MBD_NUM_CNT{1'b0}};
    // every good frame on the bus
    ev[`MBD_C_BUS] = rx_end;
    ev[`MBD_C_COMM] = rx_bad;
    ev[`MBD_C_EXC] = take && !is_bc && exc != 8'h00;
    ev[`MBD_C_SRV] = take;
    ev[`MBD_C_NORSP] = take && is_bc;
    ev[`MBD_C_NAK] = take && !is_bc && exc == `MBD_EXC_NAK;
    ev[`MBD_C_BUSY] = take && !is_bc && exc == `MBD_EXC_BUSY;
    ev[`MBD_C_OVR] = rx_ovr && addr_reg == dev_addr;
  end

  genvar gi;
  generate
    for (gi = 0; gi < `MBD_NUM_CNT; gi = gi + 1) begin : g_cnt
      reg [15:0] cnt_reg;
      always @(posedge clk_sys or negedge resetn) begin
        if (!resetn)
          cnt_reg <= 16'h0000;
        else if (clr)
          cnt_reg <= {15'h0000, ev[gi]};
        else
          cnt_reg <= cnt_reg + {15'h0000, ev[gi]};
      end
      assign cnt_flat[gi*16 +: 16] = cnt_reg;
    end
  endgenerate

  // ----------------------------------------------------------------
  // commit and reply
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      wi_reg <= 7'h00;
      resp_reg <= 48'h000000000000;
      rlen_reg <= 3'd0;
      rptr_reg <= 3'd0;
      bcast_reg <= 1'b0;
      tx_valid <= 1'b0;
      tx_byte <= 8'h00;
      tx_last <= 1'b0;
      wr_en <= 1'b0;
      wr_addr <= 16'h0000;
      wr_data <= 16'h0000;
    end else begin
      wr_en <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (take) begin
            bcast_reg <= is_bc;
            if (exc != 8'h00) begin
              resp_reg <= {addr_reg, func_reg | `MBD_EXC_FLAG, exc,
                           24'h000000};
              rlen_reg <= `MBD_LEN_EXC;
            end else begin
              // echo start and count, or sub-function and counter value for a diagnostic read; no data
              resp_reg <= {addr_reg, func_reg, w1_reg, reply_w2};
              rlen_reg <= `MBD_LEN_NORM;
            end
            rptr_reg <= 3'd0;
            wi_reg <= 7'h00;
            // a broadcast write commits, then returns to idle unanswered
            if (go_commit)
              state_reg <= ST_COMMIT;
            else if (!is_bc)
              state_reg <= ST_SEND;
          end
        end
        ST_COMMIT: begin
          // a frame that fails its checks never reaches this state
          // one register per word, rising address
          wr_en <= 1'b1;
          wr_addr <= w1_reg + {9'h000, wi_reg};
          wr_data <= buf_mem[wi_reg];
          wi_reg <= wi_reg + 7'h01;
          if ({9'h000, wi_reg} == w2_reg - 16'h0001)
            state_reg <= bcast_reg ? ST_IDLE : ST_SEND;
        end
        ST_SEND: begin
          if (!tx_valid || tx_ready) begin
            if (tx_valid && tx_last) begin
              tx_valid <= 1'b0;
              tx_last <= 1'b0;
              state_reg <= ST_IDLE;
            end else begin
              // six bytes at most; the framer appends the crc
              // high byte of each word first
              tx_valid <= 1'b1;
              tx_byte <= resp_reg[47:40];
              resp_reg <= {resp_reg[39:0], 8'h00};
              tx_last <= rptr_reg == rlen_reg - 3'd1;
              rptr_reg <= rptr_reg + 3'd1;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule // mbd_server
`default_nettype wire

// ### verification/mbd_server_props.sv
`timescale 1ns/10ps
`default_nettype none
module mbd_server_props (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [7:0] dev_addr,
  input wire logic rx_end,
  input wire logic tx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic tx_last,
  input wire logic wr_en,
  input wire logic [15:0] wr_addr
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_stall; tx_valid && !tx_ready; endsequence
  sequence s_end; tx_valid && tx_ready && tx_last; endsequence
  reply_hold_a:
    assert property (s_stall |=> tx_valid && $stable(tx_byte))
    else $error("hold");
  reply_stop_a:
    assert property (s_end |=> !tx_valid) else $error("stop");
  reply_tail_a:
    assert property ($fell(tx_valid) |-> $past(tx_last) && $past(tx_ready))
    else $error("tail");
  last_valid_a:
    assert property (tx_last |-> tx_valid) else $error("last");
  write_step_a:
    assert property (wr_en && $past(wr_en) |->
      wr_addr == $past(wr_addr) + 16'h0001) else $error("step");
  write_start_a:
    assert property ($rose(wr_en) |-> $past(rx_end, 2)) else $error("start");
  write_quiet_a:
    assert property (wr_en |-> !tx_valid) else $error("quiet");
  reply_addr_a:
    assert property ($rose(tx_valid) |-> tx_byte == dev_addr &&
      ($past(rx_end, 2) || $past(wr_en))) else $error("addr");
endmodule // mbd_server_props
`default_nettype wire

// ### verification/mbd_client.sv
`timescale 1ns/10ps
`default_nettype none
module mbd_client (
  input wire logic clk_sys,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  output logic tx_ready = 1'b0
);
  integer seed = 23825;
  logic [7:0] q[$];
  always @(posedge clk_sys) begin
    if (tx_valid && tx_ready) q.push_back(tx_byte);
    tx_ready <= $random(seed) % 3 != 0;
  end
endmodule // mbd_client
`default_nettype wire

// ### verification/mbd_server_test.sv
`timescale 1ns/10ps
`default_nettype none
module mbd_server_test;
  localparam logic [7:0] ME = 8'h21;
  logic clk_sys = 1'b0, resetn = 1'b0, server_busy = 1'b0;
  logic rx_valid = 1'b0, rx_first = 1'b0, rx_end = 1'b0;
  logic rx_bad = 1'b0, rx_ovr = 1'b0;
  logic [7:0] rx_byte = 8'h00, dev_addr = ME;
  wire logic tx_ready, tx_valid, tx_last, wr_en;
  wire logic [7:0] tx_byte;
  wire logic [15:0] wr_addr, wr_data;
  integer seed = 23825, n_fail = 0, tests_run = 0;
  logic [7:0] e[$];
  logic [31:0] ew[$];
  logic [15:0] cnt[8] = '{default: 0};
  always #10 clk_sys = ~clk_sys;
  mbd_server mbd_server_i (.*);
  mbd_client mbd_client_i (.*);
  task automatic cmp(input logic [31:0] g, x);
    tests_run++;
    if (g !== x) begin
      n_fail++;
      $display("Error %0t: got %h exp %h", $time, g, x);
    end
  endtask
  task summarize;
    $display("%0d checks, %0d errors", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk_sys)
    if (wr_en)
      cmp({wr_addr, wr_data}, ew.size() ? ew.pop_front() : 'x);
  task automatic model(input logic [7:0] f[$]);
    logic [15:0] w1, w2;
    logic [15:0] c[8];
    int ex;
    // counters as they stood before this request
    c = cnt;
    w1 = {f[2], f[3]};
    w2 = {f[4], f[5]};
    ex = 0;
    cnt[0]++;
    if (f[0] != ME && f[0] != 8'h00) return;
    cnt[3]++;
    if (f[1] == 8'h08) ex = w1 < 16'h000a || w1 > 16'h0012;
    else if (w2 < 1 || w2 > 123) ex = 3;
    else if (server_busy) ex = 6;
    else for (int k = 0; k < w2; k++)
      ew.push_back({w1 + k[15:0], f[7+2*k], f[8+2*k]});
    if (f[0] == 8'h00) cnt[4]++;
    else if (ex != 0) begin
      cnt[2]++;
      cnt[6] += ex == 6;
      e = {f[0], f[1] | 8'h80, ex[7:0]};
    end else if (f[1] == 8'h10) e = f[0:5];
    else begin
      if (w1 == 16'h000a) cnt = '{1, 0, 0, 1, 0, 0, 0, 0};
      w2 = w1 == 16'h000a ? 16'h0000 : c[w1 - 11];
      e = {f[0:3], w2[15:8], w2[7:0]};
    end
  endtask
  task automatic run(input logic [7:0] f[$], input int k = 0);
    e = {};
    if (k == 0) model(f);
    cnt[1] += k == 1;
    cnt[7] += k == 2 && f[0] == ME;
    foreach (f[i]) begin
      {rx_valid, rx_first, rx_byte} <= {1'b1, i == 0, f[i]};
      @(posedge clk_sys);
    end
    {rx_valid, rx_first, rx_end, rx_bad, rx_ovr} <=
      {2'b00, k == 0, k == 1, k == 2};
    @(posedge clk_sys);
    {rx_end, rx_bad, rx_ovr} <= 3'h0;
    repeat (300) if (mbd_client_i.q.size() < e.size() || ew.size() != 0)
      @(posedge clk_sys);
    repeat (6) @(posedge clk_sys);
    cmp(mbd_client_i.q.size(), e.size());
    foreach (e[i]) cmp(mbd_client_i.q[i], e[i]);
    cmp(ew.size(), 0);
    mbd_client_i.q = {};
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] s, input int n);
    logic [7:0] f[$];
    logic [15:0] d;
    f = {a, 8'h10, s[15:8], s[7:0], n[15:8], n[7:0], 8'(n * 2)};
    for (int k = 0; k < n; k++) begin
      d = 16'($random(seed));
      f = {f, d[15:8], d[7:0]};
    end
    run(f);
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    wr(ME, 16'h0040, 2);
    wr(ME, 16'($random(seed)), 123);
    wr(ME, 16'h0100, 0);
    wr(ME, 16'h0100, 124);
    server_busy <= 1'b1;
    @(posedge clk_sys);
    wr(ME, 16'h0200, 1);
    server_busy <= 1'b0;
    @(posedge clk_sys);
    wr(8'h00, 16'hfffe, 3);
    wr(8'h5a, 16'h0300, 1);
    run({ME, 8'h08, 8'h00, 8'h09, 8'h00, 8'h00});
    run({ME}, 1);
    run({ME}, 2);
    run({8'h5a}, 2);
    for (int r = 0; r < 2; r++) begin
      for (int s = 11; s < 19; s++)
        run({ME, 8'h08, 8'h00, 8'(s), 8'h00, 8'h00});
      run({ME, 8'h08, 8'h00, 8'h0a, 8'h00, 8'h00});
    end
    summarize;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    summarize;
  end
endmodule // mbd_server_test
bind mbd_server mbd_server_props mbd_server_props_i (.*);
`default_nettype wire
